// ### pkg/dpg_defines.vh
// constants for the dual port gpio block
// How it works
// - port e direction is write-only; reads return an undefined filler value
// - port e direction clears at power-on reset and hardware standby only
// - modes 1,2,4,5,6 with 8-bit bus: port e is gpio per direction bit
// - modes 1,2,4,5,6 with 16-bit bus: port e carries the data bus
// - modes 3 and 7: port e is gpio, each pin by its direction bit
// - port e output latch is read/write, clears at power-on and hw standby
// - port e readback is read-only; writes to it are ignored
// - port e readback gives latch where direction is 1, pin level otherwise
// - after power-on or hw standby port e readback shows pin levels
// - port e pull-up control is read/write, reset like other registers
// - pull-up on when direction 0 and pull-up bit 1, not in 16-bit bus
// - all pull-ups off after power-on reset and during hw standby
// - port f direction is write-only; reads return an undefined filler value
// - port f direction resets to 80 in bus modes, 00 in modes 3 and 7
// - standby output hold bit keeps or floats bus strobes in sw standby
// - bus modes: port f pin 7 is clock output when direction bit is 1
// - bus modes: port f pins 6 to 3 are the four bus strobes
// - modes 3 and 7: port f pins are outputs by bit, pin 7 gives clock
// - port f output latch is read/write, clears at power-on and hw standby
// - port f readback gives latch where direction is 1, pin level otherwise
`ifndef DPG_DEFINES_VH
`define DPG_DEFINES_VH
`define DPG_ADDR_E_DIR 16'hFEBD
`define DPG_ADDR_F_DIR 16'hFEBE
`define DPG_ADDR_E_PIN 16'hFF5D
`define DPG_ADDR_F_PIN 16'hFF5E
`define DPG_ADDR_E_LAT 16'hFF6D
`define DPG_ADDR_F_LAT 16'hFF6E
`define DPG_ADDR_E_PUC 16'hFF74
`define DPG_ADDR_SBY 16'hFF7A
`define DPG_SBY_HOLD_BIT 3
`define DPG_RST_ZERO 8'h00
`define DPG_RST_F_BUS 8'h80
`define DPG_UNDEF_READ 8'hFF
`define DPG_MODE_3 3'h3
`define DPG_MODE_7 3'h7
`define DPG_MODE_0 3'h0
`define DPG_CLK_PIN 7
`define DPG_AS_PIN 6
`define DPG_RD_PIN 5
`define DPG_HWR_PIN 4
`define DPG_LWR_PIN 3
`endif

// ### verilog/dpg_gpio.v
// dual 8-bit gpio port with data bus and bus strobe sharing
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "dpg_defines.vh"
module dpg_gpio (
  input wire clk,
  input wire rst_n,
  input wire hwStandby,
  input wire swStandby,
  input wire [2:0] opMode,
  input wire wideBus,
  input wire [15:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [7:0] rdData,
  input wire [7:0] portEIn,
  output wire [7:0] portEOut,
  output wire [7:0] portEOe,
  output wire [7:0] portEPullup,
  input wire [7:0] busDataOut,
  input wire busDataOe,
  output wire [7:0] busDataIn,
  input wire [7:0] portFIn,
  output wire [7:0] portFOut,
  output wire [7:0] portFOe,
  input wire sysClkOut,
  input wire address_strobe_n,
  input wire read_strobe_n,
  input wire upper_write_strobe_n,
  input wire lower_write_strobe_n
);
  reg rstMeta;
  reg rstSync;
  reg [7:0] eInMeta;
  reg [7:0] eInSync;
  reg [7:0] fInMeta;
  reg [7:0] fInSync;
  reg [7:0] port_e_direction;
  reg [7:0] port_e_output_latch;
  reg [7:0] port_e_pullup_control;
  reg [7:0] port_f_direction;
  reg [7:0] port_f_output_latch;
  reg standby_output_hold;
  reg modeSeen;
  reg [7:0] next_rdData;
  wire gpioMode;
  wire eBusMode;
  wire [7:0] eReadback;
  wire [7:0] fReadback;
  wire [7:0] fFuncOut;
  wire [7:0] fFuncOe;
  wire strobeOn;

  // reset release through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // pin synchronisers
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      eInMeta <= `DPG_RST_ZERO;
      eInSync <= `DPG_RST_ZERO;
      fInMeta <= `DPG_RST_ZERO;
      fInSync <= `DPG_RST_ZERO;
    end else begin
      eInMeta <= portEIn;
      eInSync <= eInMeta;
      fInMeta <= portFIn;
      fInSync <= fInMeta;
    end
  end

  // modes 3 and 7 are single-chip gpio modes
  assign gpioMode = (opMode == `DPG_MODE_3) || (opMode == `DPG_MODE_7);
  assign eBusMode = !gpioMode && wideBus;

  // registers; power-on reset and hw standby clear, port f direction loads 80 in bus modes, sw standby keeps
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      port_e_direction <= `DPG_RST_ZERO;
      port_e_output_latch <= `DPG_RST_ZERO;
      port_e_pullup_control <= `DPG_RST_ZERO;
      port_f_output_latch <= `DPG_RST_ZERO;
      port_f_direction <= `DPG_RST_ZERO;
      standby_output_hold <= 1'b0;
      modeSeen <= 1'b0;
    end else if (hwStandby || !modeSeen) begin
      port_e_direction <= `DPG_RST_ZERO;
      port_e_output_latch <= `DPG_RST_ZERO;
      port_e_pullup_control <= `DPG_RST_ZERO;
      port_f_output_latch <= `DPG_RST_ZERO;
      standby_output_hold <= 1'b0;
      modeSeen <= 1'b1;
      // mode strap caught after reset release
      if (gpioMode) begin
        port_f_direction <= `DPG_RST_ZERO;
      end else begin
        port_f_direction <= `DPG_RST_F_BUS;
      end
    end else if (wrStrobe) begin
      // readback addresses take no write
      case (addr)
        `DPG_ADDR_E_DIR: port_e_direction <= wrData;
        `DPG_ADDR_E_LAT: port_e_output_latch <= wrData;
        `DPG_ADDR_E_PUC: port_e_pullup_control <= wrData;
        `DPG_ADDR_F_DIR: port_f_direction <= wrData;
        `DPG_ADDR_F_LAT: port_f_output_latch <= wrData;
        `DPG_ADDR_SBY: begin
          standby_output_hold <= wrData[`DPG_SBY_HOLD_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // readback mixes latch and synced pin levels per direction bit
  assign eReadback = (port_e_direction & port_e_output_latch) |
    (~port_e_direction & eInSync);
  assign fReadback = (port_f_direction & port_f_output_latch) |
    (~port_f_direction & fInSync);

  // read mux
  always @* begin
    next_rdData = `DPG_RST_ZERO;
    case (addr)
      `DPG_ADDR_E_DIR: next_rdData = `DPG_UNDEF_READ;
      `DPG_ADDR_F_DIR: next_rdData = `DPG_UNDEF_READ;
      `DPG_ADDR_E_PIN: next_rdData = eReadback;
      `DPG_ADDR_F_PIN: next_rdData = fReadback;
      `DPG_ADDR_E_LAT: next_rdData = port_e_output_latch;
      `DPG_ADDR_F_LAT: next_rdData = port_f_output_latch;
      `DPG_ADDR_E_PUC: next_rdData = port_e_pullup_control;
      `DPG_ADDR_SBY: begin
        next_rdData = `DPG_RST_ZERO;
        next_rdData[`DPG_SBY_HOLD_BIT] = standby_output_hold;
      end
      default: next_rdData = `DPG_RST_ZERO;
    endcase
  end

  // read data valid the cycle after the strobe
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      rdData <= `DPG_RST_ZERO;
    end else if (rdStrobe) begin
      rdData <= next_rdData;
    end else begin
      rdData <= `DPG_RST_ZERO;
    end
  end

  // port e pins: data bus in 16-bit bus mode, else gpio
  assign portEOut = eBusMode ? busDataOut : port_e_output_latch;
  assign portEOe = eBusMode ? {8{busDataOe}} : port_e_direction;
  assign busDataIn = eInSync;
  assign portEPullup = eBusMode ? `DPG_RST_ZERO :
    (~port_e_direction & port_e_pullup_control);

  // strobes float in sw standby unless hold is set
  assign strobeOn = !swStandby || standby_output_hold;

  // port f special functions per pin
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gF
      if (i == `DPG_CLK_PIN) begin : gClk
        assign fFuncOut[i] = sysClkOut;
        assign fFuncOe[i] = port_f_direction[i];
      end else if (i >= `DPG_LWR_PIN && i <= `DPG_AS_PIN) begin : gStb
        assign fFuncOut[i] = gpioMode ? port_f_output_latch[i] :
          (i == `DPG_AS_PIN) ? address_strobe_n :
          (i == `DPG_RD_PIN) ? read_strobe_n :
          (i == `DPG_HWR_PIN) ? upper_write_strobe_n :
          lower_write_strobe_n;
        assign fFuncOe[i] = gpioMode ? port_f_direction[i] : strobeOn;
      end else begin : gIo
        assign fFuncOut[i] = port_f_output_latch[i];
        assign fFuncOe[i] = port_f_direction[i];
      end
    end
  endgenerate
  assign portFOut = fFuncOut;
  assign portFOe = fFuncOe;
endmodule

// ### verif/dpg_gpio_monitor.sv
// checker for the dual port gpio block
`timescale 1ns/10ps
module dpg_gpio_monitor (
  input wire clk,
  input wire rst_n,
  input wire hwStandby,
  input wire swStandby,
  input wire [2:0] opMode,
  input wire wideBus,
  input wire [15:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  input wire [7:0] rdData,
  input wire [7:0] portEOut,
  input wire [7:0] portEOe,
  input wire [7:0] portEPullup,
  input wire busDataOe,
  input wire [7:0] portFOut,
  input wire [7:0] portFOe,
  input wire sysClkOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // gpio modes versus bus modes, writes outside hw standby
  wire gp = opMode == 3'h3 || opMode == 3'h7;
  wire eBus = wideBus && !gp;
  wire wrOk = wrStrobe && !hwStandby;
  a_e_bus_oe: assert property (eBus |-> portEOe == {8{busDataOe}})
    else $error("port e not handed to data bus");
  a_e_pull_bus: assert property (eBus |-> portEPullup == 8'h00)
    else $error("pull-up on in wide bus mode");
  a_e_dir_wr: assert property (wrOk && addr == 16'hFEBD && !eBus ##1 !eBus
    |-> portEOe == $past(wrData))
    else $error("port e direction write not applied");
  a_e_lat_wr: assert property (wrOk && addr == 16'hFF6D ##1 !eBus
    |-> portEOut == $past(wrData))
    else $error("port e latch write not applied");
  a_hw_clear: assert property (hwStandby && !eBus ##1 !eBus
    |-> portEOe == 8'h00 && portEPullup == 8'h00)
    else $error("hw standby left port e driven");
  a_dir_read: assert property (rdStrobe && !hwStandby &&
    (addr == 16'hFEBD || addr == 16'hFEBE) |=> rdData == 8'hFF)
    else $error("direction read not filler");
  a_f_strobes: assert property (!gp && !swStandby
    |-> portFOe[6:3] == 4'hF)
    else $error("bus strobes not driven");
  a_f_clock: assert property (portFOe[7] |-> portFOut[7] == sysClkOut)
    else $error("clock pin not carrying clock");
  cover property (wrOk && addr == 16'hFF6D);
  cover property (eBus && busDataOe);
  cover property (hwStandby && gp);
  cover property (swStandby && !gp);
endmodule
bind dpg_gpio dpg_gpio_monitor mon (.*);

// ### verif/dpg_board.sv
// board model: external drivers, pull-ups and floating pins
`timescale 1ns/10ps
module dpg_board (
  input wire [7:0] portEOut,
  input wire [7:0] portEOe,
  input wire [7:0] portEPullup,
  input wire [7:0] portFOut,
  input wire [7:0] portFOe,
  input wire [7:0] extE,
  input wire [7:0] extEOe,
  input wire [7:0] extF,
  output wire [7:0] portEIn,
  output wire [7:0] portFIn
);
  // device wins, then board, then pull-up, else inverse of last drive
  assign portEIn = portEOe & portEOut | ~portEOe & (extEOe & extE |
    ~extEOe & (portEPullup | ~portEOut));
  // board drives every port f pin the device leaves alone
  assign portFIn = portFOe & portFOut | ~portFOe & extF;
endmodule

// ### verif/dpg_gpio_tb.sv
// self-checking bench for the dual port gpio block
`timescale 1ns/10ps
module dpg_gpio_tb;
  reg clk = 1'b0, rst_n = 1'b0, hwStandby = 1'b0, swStandby = 1'b0;
  reg wideBus = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0, busDataOe = 1'b0;
  reg [2:0] opMode = 3'h1;
  reg [15:0] addr = 16'h0000;
  reg [7:0] wrData = 8'h00, busDataOut = 8'h00, extE = 8'h3C;
  reg [7:0] extEOe = 8'hFF, extF = 8'hC3;
  wire [7:0] rdData, portEOut, portEOe, portEPullup, portEIn, portFIn;
  wire [7:0] portFOut, portFOe, busDataIn;
  wire sysClkOut = clk;
  wire address_strobe_n = 1'b1, read_strobe_n = 1'b0;
  wire upper_write_strobe_n = 1'b1, lower_write_strobe_n = 1'b0;
  integer num_errors = 0, checks = 0;
  always #12.5 clk = ~clk;
  dpg_gpio DUT (.*);
  dpg_board board (.*);
  task chk(input [8*8:1] nm, input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 chk("rdData", rdData, exp);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // reset values, port e gpio and pull-ups, then mode 7 port f
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(16'hFEBD, 8'hFF);
    rd(16'hFEBE, 8'hFF);
    rd(16'hFF6D, 8'h00);
    rd(16'hFF74, 8'h00);
    rd(16'hFF5D, 8'h3C);
    rd(16'hFF5E, 8'h53);
    chk("portFOe", portFOe, 8'hF8);
    wr(16'hFEBD, 8'h0F);
    wr(16'hFF6D, 8'hA5);
    wr(16'hFF5D, 8'h00);
    rd(16'hFF6D, 8'hA5);
    rd(16'hFF5D, 8'h35);
    chk("portEOe", portEOe, 8'h0F);
    wr(16'hFF74, 8'hF0);
    extEOe <= 8'h00;
    repeat (3) @(posedge clk);
    rd(16'hFF74, 8'hF0);
    rd(16'hFF5D, 8'hF5);
    wideBus <= 1'b1;
    busDataOe <= 1'b1;
    busDataOut <= 8'h96;
    @(posedge clk);
    #1 chk("pullup", portEPullup, 8'h00);
    chk("portEOe", portEOe, 8'hFF);
    chk("portEOut", portEOut, 8'h96);
    chk("strobes", portFOut & 8'h78, 8'h50);
    // sw standby floats the strobes until the hold bit is set
    swStandby <= 1'b1;
    @(posedge clk);
    #1 chk("portFOe", portFOe, 8'h80);
    wr(16'hFF7A, 8'h08);
    #1 chk("portFOe", portFOe, 8'hF8);
    swStandby <= 1'b0;
    wideBus <= 1'b0;
    opMode <= 3'h7;
    hwStandby <= 1'b1;
    repeat (2) @(posedge clk);
    hwStandby <= 1'b0;
    @(posedge clk);
    #1 chk("portFOe", portFOe, 8'h00);
    chk("portEOe", portEOe, 8'h00);
    rd(16'hFF6D, 8'h00);
    rd(16'hFF74, 8'h00);
    wr(16'hFEBE, 8'h0F);
    wr(16'hFF6E, 8'h5A);
    repeat (2) @(posedge clk);
    rd(16'hFF5E, 8'hCA);
    chk("portFOut", {4'h0, portFOut[3:0]}, 8'h0A);
    swStandby <= 1'b1;
    rd(16'hFF6E, 8'h5A);
    finish_test;
  end
endmodule
